// >>> pkg/pvc_defines.vh
/*
 constants for the port u / port v pin control block: register offsets,
 reset values, settle timing and interrupt bit positions.
 assumes: included by bare name from core files.
*/
`ifndef PVC_DEFINES_VH
`define PVC_DEFINES_VH

// =====================================================================
// register map (byte offsets on the plain register port)
`define PVC_ADDR_W 10
`define PVC_OFF_PULL_EN 10'h294
`define PVC_OFF_POLARITY 10'h295
`define PVC_OFF_SLEW 10'h296
`define PVC_OFF_RSVD 10'h297
`define PVC_OFF_V_DATA 10'h298
`define PVC_OFF_V_DIR 10'h299
`define PVC_OFF_IRQ_STAT 10'h29A
`define PVC_OFF_IRQ_MASK 10'h29B
`define PVC_OFF_SLEW_STAT 10'h29C

// =====================================================================
// reset values
`define PVC_RST_BYTE 8'h00
`define PVC_RSVD_READ 8'h00
`define PVC_IBUF_RST 8'hFF

// =====================================================================
// timing: clock period and settle time in ns
`define PVC_CLK_NS 100
`define PVC_SETTLE_NS 300
`define PVC_CNT_W 4

// =====================================================================
// interrupt status bits: settle done, stop entered
`define PVC_IRQ_SETTLE 0
`define PVC_IRQ_STOP 1

`endif

// >>> core/pvc_slew_settle.v
/*
 slew settle timer: counts bus clocks after a zero/non-zero change of
 the slew register or a stop-mode exit, then releases slew control.
 assumes: i_stop is already synchronous to i_ref_clk.
*/
`timescale 1ns/1ps
`include "pvc_defines.vh"

module pvc_slew_settle (
   input wire i_ref_clk,
   input wire i_reset,
   input wire i_restart,
   input wire i_stop,
   output reg o_settled,
   output wire o_done_pulse
);

   // =====================================================================
   // cycle count, rounded up as a least time
   localparam integer SETTLE_INT =
      (`PVC_SETTLE_NS + `PVC_CLK_NS - 1) / `PVC_CLK_NS;
   localparam [`PVC_CNT_W-1:0] SETTLE_CYC = SETTLE_INT[`PVC_CNT_W-1:0];

   reg [`PVC_CNT_W-1:0] count;
   reg [`PVC_CNT_W-1:0] next_count;
   reg next_settled;

   always @* begin
      next_count = count;
      next_settled = o_settled;
      if (i_stop) begin
         // held off during stop; a fresh interval runs on wakeup
         next_count = SETTLE_CYC;
         next_settled = 1'b0;
      end else if (i_restart) begin
         next_count = SETTLE_CYC;
         next_settled = 1'b0;
      end else if (count != {`PVC_CNT_W{1'b0}}) begin
         next_count = count - {{(`PVC_CNT_W-1){1'b0}}, 1'b1};
         next_settled = (count == {{(`PVC_CNT_W-1){1'b0}}, 1'b1});
      end
   end

   assign o_done_pulse = next_settled & ~o_settled;

   always @(posedge i_ref_clk) begin
      if (i_reset) begin
         count <= {`PVC_CNT_W{1'b0}};
         o_settled <= 1'b1;
      end else begin
         count <= next_count;
         o_settled <= next_settled;
      end
   end

endmodule

// >>> core/pvc_pin_ctrl.v
/*
 pin control for port u (pull polarity, edge select, slew) and port v
 (data register, read-back, pin ownership), with a plain register port
 and one level interrupt.
 assumes: pins arrive asynchronous and are synchronised here; peripheral
 enables and outputs come from logic on i_ref_clk.
*/
// Decided for this implementation: the address-and-strobe port.
// Behaviour
// - polarity bit also picks interrupt edge
// - polarity 0 pull-up, 1 pull-down, gated
// - slew bit on disables input buffer
// - slew change settles after about 300 ns
// - stop forces slew off, resettles on wake
// - reserved address reads zero, ignores writes
// - port v read: latch if output, else pin
// - bits 7,5: motor pwm over gpio
// - bits 6,4: motor, timer, then gpio
// - polarity and slew writable any time
// - bit 3: motor, iic, pwm_channel_seven, spi, gpio
// - pull enables reset cleared
`timescale 1ns/1ps
`include "pvc_defines.vh"

module pvc_pin_ctrl (
   input wire i_ref_clk,
   input wire i_reset,
   input wire [`PVC_ADDR_W-1:0] i_addr,
   input wire [7:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output reg [7:0] o_rdata,
   input wire [7:0] i_port_u_dir,
   input wire [7:0] i_port_u_pin,
   input wire i_stop,
   output reg [7:0] o_port_u_pull_up,
   output reg [7:0] o_port_u_pull_down,
   output reg [7:0] o_port_u_slew_on,
   output reg [7:0] o_port_u_ibuf_en,
   output reg [7:0] o_port_u_edge_event,
   input wire [7:0] i_port_v_pin,
   output reg [7:0] o_port_v_out,
   output reg [7:0] o_port_v_oe,
   input wire [7:0] i_motor_en,
   input wire [7:0] i_motor_out,
   input wire [3:0] i_second_timer_en,
   input wire [3:0] i_second_timer_out,
   input wire i_iic_sda_en,
   input wire i_iic_sda_out,
   input wire i_pwm_channel_seven_en,
   input wire i_pwm_channel_seven_out,
   input wire i_spi_select_en,
   input wire i_spi_select_out,
   output wire o_irq
);

   // =====================================================================
   // registers
   reg [7:0] port_u_pull_enable;
   reg [7:0] port_u_pull_polarity;
   reg [7:0] port_u_slew_control;
   reg [7:0] port_v_data;
   reg [7:0] port_v_direction;
   reg [7:0] irq_status;
   reg [7:0] irq_mask;
   reg [7:0] u_meta;
   reg [7:0] u_sync;
   reg [7:0] u_prev;
   reg [7:0] v_meta;
   reg [7:0] v_sync;
   reg [7:0] irq_u_status;
   reg stop_meta;
   reg stop_sync;
   reg stop_prev;

   // =====================================================================
   // address decode shared by the write and status paths
   function reg_hit;
      input strobe;
      input [`PVC_ADDR_W-1:0] addr;
      input [`PVC_ADDR_W-1:0] off;
      begin
         reg_hit = strobe & (addr == off);
      end
   endfunction

   wire wr_pol = reg_hit(i_wr, i_addr, `PVC_OFF_POLARITY);
   wire wr_slew = reg_hit(i_wr, i_addr, `PVC_OFF_SLEW);
   wire slew_nz_new = (i_wdata != `PVC_RST_BYTE);
   wire slew_nz_old = (port_u_slew_control != `PVC_RST_BYTE);
   wire slew_restart = wr_slew & (slew_nz_new != slew_nz_old);
   wire settled;
   wire settle_done;

   // =====================================================================
   // settle timer
   pvc_slew_settle u_settle (
      .i_ref_clk(i_ref_clk),
      .i_reset(i_reset),
      .i_restart(slew_restart),
      .i_stop(stop_sync),
      .o_settled(settled),
      .o_done_pulse(settle_done)
   );

   // =====================================================================
   // port u pad controls
   always @(posedge i_ref_clk) begin
      if (i_reset) begin
         o_port_u_pull_up <= `PVC_RST_BYTE;
         o_port_u_pull_down <= `PVC_RST_BYTE;
         o_port_u_slew_on <= `PVC_RST_BYTE;
         o_port_u_ibuf_en <= `PVC_IBUF_RST;
      end else begin
         o_port_u_pull_up <= port_u_pull_enable & ~i_port_u_dir &
            ~port_u_pull_polarity;
         o_port_u_pull_down <= port_u_pull_enable & ~i_port_u_dir &
            port_u_pull_polarity;
         // old setting holds until settled; stop forces slew off and input buffers on
         if (stop_sync) begin
            o_port_u_slew_on <= `PVC_RST_BYTE;
            o_port_u_ibuf_en <= `PVC_IBUF_RST;
         end else if (settled) begin
            o_port_u_slew_on <= port_u_slew_control;
            o_port_u_ibuf_en <= ~port_u_slew_control;
         end
      end
   end

   // edge sense: polarity 0 selects falling, 1 selects rising
   wire [7:0] rise = u_sync & ~u_prev;
   wire [7:0] fall = ~u_sync & u_prev;
   wire [7:0] edge_hit = (port_u_pull_polarity & rise) |
      (~port_u_pull_polarity & fall);

   always @(posedge i_ref_clk) begin
      if (i_reset) begin
         o_port_u_edge_event <= `PVC_RST_BYTE;
      end else begin
         o_port_u_edge_event <= edge_hit;
      end
   end

   // =====================================================================
   // synchronisers
   always @(posedge i_ref_clk) begin
      if (i_reset) begin
         u_meta <= `PVC_RST_BYTE;
         u_sync <= `PVC_RST_BYTE;
         u_prev <= `PVC_RST_BYTE;
         v_meta <= `PVC_RST_BYTE;
         v_sync <= `PVC_RST_BYTE;
         stop_meta <= 1'b0;
         stop_sync <= 1'b0;
         stop_prev <= 1'b0;
      end else begin
         u_meta <= i_port_u_pin;
         u_sync <= u_meta;
         u_prev <= u_sync;
         v_meta <= i_port_v_pin;
         v_sync <= v_meta;
         stop_meta <= i_stop;
         stop_sync <= stop_meta;
         stop_prev <= stop_sync;
      end
   end

   // =====================================================================
   // port v pin ownership
   function [1:0] pick_owner;
      // 2'h2 motor, 2'h1 alternative, 2'h0 general purpose
      input motor_en;
      input alt_en;
      begin
         if (motor_en)
            pick_owner = 2'h2;
         else if (alt_en)
            pick_owner = 2'h1;
         else
            pick_owner = 2'h0;
      end
   endfunction

   function [1:0] timer_chan;
      // bit 4 carries timer channel 2, bit 6 channel 3
      input [2:0] bit_pos;
      begin
         timer_chan = bit_pos[2:1];
      end
   endfunction

   reg [7:0] next_v_out;
   reg [7:0] next_v_oe;
   reg alt3_en;
   reg alt3_out;
   integer b;

   always @* begin
      next_v_out = port_v_data;
      next_v_oe = port_v_direction;
      alt3_en = 1'b0;
      alt3_out = 1'b0;
      // bit 3 chain below motor: iic, pwm seven, spi select
      if (i_iic_sda_en) begin
         alt3_en = 1'b1;
         alt3_out = i_iic_sda_out;
      end else if (i_pwm_channel_seven_en) begin
         alt3_en = 1'b1;
         alt3_out = i_pwm_channel_seven_out;
      end else if (i_spi_select_en) begin
         alt3_en = 1'b1;
         alt3_out = i_spi_select_out;
      end
      for (b = 4; b < 8; b = b + 1) begin
         case (pick_owner(i_motor_en[b],
            (b == 4 || b == 6) ? i_second_timer_en[timer_chan(b[2:0])] :
            1'b0))
            2'h2: begin
               next_v_out[b] = i_motor_out[b];
               next_v_oe[b] = 1'b1;
            end
            2'h1: begin
               next_v_out[b] = i_second_timer_out[timer_chan(b[2:0])];
               next_v_oe[b] = 1'b1;
            end
            default: begin
               next_v_out[b] = port_v_data[b];
               next_v_oe[b] = port_v_direction[b];
            end
         endcase
      end
      case (pick_owner(i_motor_en[3], alt3_en))
         2'h2: begin
            next_v_out[3] = i_motor_out[3];
            next_v_oe[3] = 1'b1;
         end
         2'h1: begin
            next_v_out[3] = alt3_out;
            next_v_oe[3] = 1'b1;
         end
         default: begin
            next_v_out[3] = port_v_data[3];
            next_v_oe[3] = port_v_direction[3];
         end
      endcase
      // bits 2..0 here carry only motor over general purpose; their
      // own alternate chains belong to another block
      for (b = 0; b < 3; b = b + 1) begin
         if (i_motor_en[b]) begin
            next_v_out[b] = i_motor_out[b];
            next_v_oe[b] = 1'b1;
         end
      end
   end

   always @(posedge i_ref_clk) begin
      if (i_reset) begin
         o_port_v_out <= `PVC_RST_BYTE;
         o_port_v_oe <= `PVC_RST_BYTE;
      end else begin
         o_port_v_out <= next_v_out;
         o_port_v_oe <= next_v_oe;
      end
   end

   // =====================================================================
   // register writes and sticky interrupt flags (set beats clear)
   reg [7:0] irq_evt;

   always @* begin
      irq_evt = `PVC_RST_BYTE;
      irq_evt[`PVC_IRQ_SETTLE] = settle_done;
      irq_evt[`PVC_IRQ_STOP] = stop_sync & ~stop_prev;
   end

   always @(posedge i_ref_clk) begin
      if (i_reset) begin
         port_u_pull_enable <= `PVC_RST_BYTE;
         port_u_pull_polarity <= `PVC_RST_BYTE;
         port_u_slew_control <= `PVC_RST_BYTE;
         port_v_data <= `PVC_RST_BYTE;
         port_v_direction <= `PVC_RST_BYTE;
         irq_status <= `PVC_RST_BYTE;
         irq_mask <= `PVC_RST_BYTE;
         irq_u_status <= `PVC_RST_BYTE;
      end else begin
         if (reg_hit(i_wr, i_addr, `PVC_OFF_PULL_EN))
            port_u_pull_enable <= i_wdata;
         if (wr_pol)
            port_u_pull_polarity <= i_wdata;
         if (wr_slew)
            port_u_slew_control <= i_wdata;
         if (reg_hit(i_wr, i_addr, `PVC_OFF_V_DATA))
            port_v_data <= i_wdata;
         if (reg_hit(i_wr, i_addr, `PVC_OFF_V_DIR))
            port_v_direction <= i_wdata;
         if (reg_hit(i_wr, i_addr, `PVC_OFF_IRQ_MASK))
            irq_mask <= i_wdata;
         if (reg_hit(i_wr, i_addr, `PVC_OFF_IRQ_STAT))
            irq_status <= (irq_status & ~i_wdata) | irq_evt;
         else
            irq_status <= irq_status | irq_evt;
         // port u edge flags have their own slot and stay off o_irq
         if (reg_hit(i_wr, i_addr, `PVC_OFF_SLEW_STAT))
            irq_u_status <= (irq_u_status & ~i_wdata) | edge_hit;
         else
            irq_u_status <= irq_u_status | edge_hit;
      end
   end

   assign o_irq = |(irq_status & irq_mask);

   // =====================================================================
   // read data, one cycle after the strobe
   // input bits pass the synchroniser first, so a pin change shows in the
   // read value two cycles later; a direction change switches the mux at once
   wire [7:0] v_read = (port_v_direction & port_v_data) |
      (~port_v_direction & v_sync);

   always @(posedge i_ref_clk) begin
      if (i_reset) begin
         o_rdata <= `PVC_RST_BYTE;
      end else if (i_rd) begin
         case (i_addr)
            `PVC_OFF_PULL_EN: o_rdata <= port_u_pull_enable;
            `PVC_OFF_POLARITY: o_rdata <= port_u_pull_polarity;
            `PVC_OFF_SLEW: o_rdata <= port_u_slew_control;
            `PVC_OFF_RSVD: o_rdata <= `PVC_RSVD_READ;
            `PVC_OFF_V_DATA: o_rdata <= v_read;
            `PVC_OFF_V_DIR: o_rdata <= port_v_direction;
            `PVC_OFF_IRQ_STAT: o_rdata <= irq_status;
            `PVC_OFF_IRQ_MASK: o_rdata <= irq_mask;
            `PVC_OFF_SLEW_STAT: o_rdata <= irq_u_status;
            default: o_rdata <= `PVC_RST_BYTE;
         endcase
      end else begin
         o_rdata <= `PVC_RST_BYTE;
      end
   end

endmodule

// >>> tb/pvc_pin_ctrl_sva.sv
/*
 checker for the port u / port v pin control block.
 assumes: bound to pvc_pin_ctrl, one clock, synchronous reset.
*/
`timescale 1ns/1ps
`include "pvc_defines.vh"
module pvc_pin_ctrl_sva (
   input wire i_ref_clk,
   input wire i_reset,
   input wire [`PVC_ADDR_W-1:0] i_addr,
   input wire [7:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   input wire [7:0] o_rdata,
   input wire i_stop,
   input wire [7:0] o_port_u_pull_up,
   input wire [7:0] o_port_u_pull_down,
   input wire [7:0] o_port_u_slew_on,
   input wire [7:0] o_port_u_ibuf_en,
   input wire [7:0] o_port_v_out,
   input wire [7:0] o_port_v_oe,
   input wire [7:0] i_motor_en,
   input wire [7:0] i_motor_out,
   input wire [3:0] i_second_timer_en,
   input wire [3:0] i_second_timer_out,
   input wire i_iic_sda_en,
   input wire i_iic_sda_out
);
   // =================================================================
   // helper: alternates held since the last edge
   wire [25:0] alt = {i_motor_en, i_motor_out, i_second_timer_en,
      i_second_timer_out, i_iic_sda_en, i_iic_sda_out};
   reg [25:0] alt_q;
   reg rst_q;
   always @(posedge i_ref_clk) begin
      alt_q <= alt;
      rst_q <= i_reset;
   end
   // registered outputs need one quiet cycle before they must follow
   wire calm = !rst_q && alt_q == alt;
   wire slew_go = i_wr && i_addr == `PVC_OFF_SLEW && i_wdata != 8'h00
      && o_port_u_slew_on == 8'h00 && !i_stop;
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_reset);
   // =================================================================
   // properties
   property p_ibuf;
      o_port_u_ibuf_en == ~o_port_u_slew_on;
   endproperty
   a_ibuf: assert property (p_ibuf) else $error("ibuf not inverse");
   property p_pull_excl;
      (o_port_u_pull_up & o_port_u_pull_down) == 8'h00;
   endproperty
   a_pull_excl: assert property (p_pull_excl) else $error("pull clash");
   property p_pull_rst;
      $fell(i_reset) |-> (o_port_u_pull_up | o_port_u_pull_down) == 8'h00;
   endproperty
   a_pull_rst: assert property (p_pull_rst) else $error("pull after reset");
   property p_rsvd;
      i_rd && i_addr == `PVC_OFF_RSVD |=> o_rdata == `PVC_RSVD_READ;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved not zero");
   property p_stop;
      i_stop [*6] |-> o_port_u_slew_on == 8'h00;
   endproperty
   a_stop: assert property (p_stop) else $error("slew on in stop");
   property p_settle_hold;
      slew_go |=> (o_port_u_slew_on == 8'h00) [*2];
   endproperty
   a_settle_hold: assert property (p_settle_hold) else $error("slew early");
   property p_settle_done;
      slew_go |-> ##[3:8] o_port_u_slew_on != 8'h00;
   endproperty
   a_settle_done: assert property (p_settle_done) else $error("slew late");
   property p_motor7;
      calm && i_motor_en[7] |-> o_port_v_oe[7]
         && o_port_v_out[7] == i_motor_out[7];
   endproperty
   a_motor7: assert property (p_motor7) else $error("bit7 owner");
   property p_timer6;
      calm && !i_motor_en[6] && i_second_timer_en[3]
         |-> o_port_v_out[6] == i_second_timer_out[3];
   endproperty
   a_timer6: assert property (p_timer6) else $error("bit6 owner");
   property p_iic3;
      calm && !i_motor_en[3] && i_iic_sda_en
         |-> o_port_v_out[3] == i_iic_sda_out;
   endproperty
   a_iic3: assert property (p_iic3) else $error("bit3 owner");
endmodule
bind pvc_pin_ctrl pvc_pin_ctrl_sva i_pvc_pin_ctrl_sva (.i_ref_clk,
   .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_stop,
   .o_port_u_pull_up, .o_port_u_pull_down, .o_port_u_slew_on,
   .o_port_u_ibuf_en, .o_port_v_out, .o_port_v_oe, .i_motor_en,
   .i_motor_out, .i_second_timer_en, .i_second_timer_out,
   .i_iic_sda_en, .i_iic_sda_out);

// >>> tb/pvc_pin_model.sv
/*
 pads of port u and port v as seen from outside.
 assumes: bench decides when port u is driven and what port v sees.
*/
`timescale 1ns/1ps
module pvc_pin_model (
   input wire i_ref_clk,
   input wire i_drive_en,
   input wire [7:0] i_drive,
   input wire [7:0] i_pull_up,
   input wire [7:0] i_pull_down,
   input wire [7:0] i_port_v_ext,
   input wire [7:0] i_port_v_out,
   input wire [7:0] i_port_v_oe,
   output wire [7:0] o_port_u_pin,
   output wire [7:0] o_port_v_pin
);
   reg [7:0] spin = 8'h5A;
   always @(posedge i_ref_clk) begin
      spin <= ~spin;
   end
   // floating pins wander so a stale level is never mistaken for a pull
   assign o_port_u_pin = i_drive_en ? i_drive :
      i_pull_up | (spin & ~i_pull_down);
   assign o_port_v_pin = (i_port_v_oe & i_port_v_out)
      | (~i_port_v_oe & i_port_v_ext);
endmodule

// >>> tb/tb.sv
/*
 self-checking bench for pvc_pin_ctrl.
 assumes: 10 MHz clock, register port answers one cycle after a read.
*/
`timescale 1ns/1ps
`include "pvc_defines.vh"
module tb;
   reg i_ref_clk = 1'b0;
   reg i_reset = 1'b1;
   reg [`PVC_ADDR_W-1:0] i_addr = 10'h000;
   reg [7:0] i_wdata = 8'h00;
   reg i_wr = 1'b0;
   reg i_rd = 1'b0;
   reg [7:0] i_port_u_dir = 8'h00;
   reg i_stop = 1'b0;
   reg [7:0] i_motor_en = 8'h00;
   reg [7:0] i_motor_out = 8'h00;
   reg [3:0] i_second_timer_en = 4'h0;
   reg [3:0] i_second_timer_out = 4'h0;
   reg [5:0] b3 = 6'h00;
   reg drv_en = 1'b0;
   reg [7:0] drv = 8'h00;
   reg [7:0] v_ext = 8'h00;
   wire [7:0] o_rdata, pu, pd, slew, ibuf, edge_ev, u_pin, v_pin, v_out, v_oe;
   wire o_irq;
   integer errors = 0;
   integer checks = 0;
   always #50 i_ref_clk = ~i_ref_clk;
   pvc_pin_ctrl i_pvc_pin_ctrl (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata), .i_port_u_dir(i_port_u_dir),
      .i_port_u_pin(u_pin), .i_stop(i_stop), .o_port_u_pull_up(pu),
      .o_port_u_pull_down(pd), .o_port_u_slew_on(slew),
      .o_port_u_ibuf_en(ibuf), .o_port_u_edge_event(edge_ev),
      .i_port_v_pin(v_pin), .o_port_v_out(v_out), .o_port_v_oe(v_oe),
      .i_motor_en(i_motor_en), .i_motor_out(i_motor_out),
      .i_second_timer_en(i_second_timer_en),
      .i_second_timer_out(i_second_timer_out), .i_iic_sda_en(b3[5]),
      .i_iic_sda_out(b3[4]), .i_pwm_channel_seven_en(b3[3]),
      .i_pwm_channel_seven_out(b3[2]), .i_spi_select_en(b3[1]),
      .i_spi_select_out(b3[0]), .o_irq(o_irq));
   pvc_pin_model i_pvc_pin_model (.i_ref_clk(i_ref_clk), .i_drive_en(drv_en),
      .i_drive(drv), .i_pull_up(pu), .i_pull_down(pd), .i_port_v_ext(v_ext),
      .i_port_v_out(v_out), .i_port_v_oe(v_oe), .o_port_u_pin(u_pin),
      .o_port_v_pin(v_pin));
   // =================================================================
   // shared tasks
   task chk(input string n, input [7:0] s, input [7:0] e);
      begin
         checks = checks + 1;
         if (s !== e) begin
            errors = errors + 1;
            $display("FAIL %0s expected %h seen %h", n, e, s);
         end
      end
   endtask
   task cyc(input integer n);
      begin
         repeat (n) @(posedge i_ref_clk);
         #1;
      end
   endtask
   task wr(input [9:0] a, input [7:0] d);
      begin
         @(posedge i_ref_clk);
         i_wr <= 1'b1;
         i_addr <= a;
         i_wdata <= d;
         @(posedge i_ref_clk);
         i_wr <= 1'b0;
      end
   endtask
   task rdc(input string n, input [9:0] a, input [7:0] e);
      begin
         @(posedge i_ref_clk);
         i_rd <= 1'b1;
         i_addr <= a;
         @(posedge i_ref_clk);
         i_rd <= 1'b0;
         #1 chk(n, o_rdata, e);
      end
   endtask
   task cap(output [7:0] m);
      begin
         m = 8'h00;
         repeat (6) begin
            @(posedge i_ref_clk);
            #1 m = m | edge_ev;
         end
      end
   endtask
   // =================================================================
   // scenarios
   task t_reset;
      begin
         chk("pull_up", pu, 8'h00);
         chk("pull_dn", pd, 8'h00);
         chk("ibuf", ibuf, 8'hFF);
         rdc("pull_en", `PVC_OFF_PULL_EN, 8'h00);
         rdc("v_data", `PVC_OFF_V_DATA, 8'h00);
         $display("test reset done");
      end
   endtask
   task t_rsvd;
      begin
         wr(`PVC_OFF_RSVD, 8'hFF);
         rdc("rsvd", `PVC_OFF_RSVD, 8'h00);
         rdc("unmapped", 10'h3FF, 8'h00);
         $display("test reserved done");
      end
   endtask
   task t_pull;
      reg [7:0] m;
      begin
         @(posedge i_ref_clk) i_port_u_dir <= 8'hC3;
         wr(`PVC_OFF_PULL_EN, 8'hFF);
         wr(`PVC_OFF_POLARITY, 8'h0F);
         cyc(3);
         chk("pull_up", pu, 8'h30);
         chk("pull_dn", pd, 8'h0C);
         rdc("polarity", `PVC_OFF_POLARITY, 8'h0F);
         @(posedge i_ref_clk) i_port_u_dir <= 8'h00;
         drv_en <= 1'b1;
         cyc(6);
         drv <= 8'hFF;
         cap(m);
         chk("rise", m, 8'h0F);
         drv <= 8'h00;
         cap(m);
         chk("fall", m, 8'hF0);
         $display("test pull done");
      end
   endtask
   task t_slew;
      begin
         wr(`PVC_OFF_SLEW, 8'h01);
         cyc(8);
         chk("slew", slew, 8'h01);
         chk("ibuf", ibuf, 8'hFE);
         rdc("slew_reg", `PVC_OFF_SLEW, 8'h01);
         rdc("stat", `PVC_OFF_IRQ_STAT, 8'h01);
         chk("irq_off", {7'h00, o_irq}, 8'h00);
         wr(`PVC_OFF_IRQ_MASK, 8'h01);
         cyc(1);
         chk("irq_on", {7'h00, o_irq}, 8'h01);
         wr(`PVC_OFF_IRQ_STAT, 8'h01);
         cyc(1);
         chk("irq_clr", {7'h00, o_irq}, 8'h00);
         $display("test slew done");
      end
   endtask
   task t_stop;
      begin
         @(posedge i_ref_clk) i_stop <= 1'b1;
         cyc(8);
         chk("stop_slew", slew, 8'h00);
         chk("stop_ibuf", ibuf, 8'hFF);
         rdc("stat", `PVC_OFF_IRQ_STAT, 8'h02);
         chk("irq_mask", {7'h00, o_irq}, 8'h00);
         i_stop <= 1'b0;
         cyc(3);
         chk("wake_early", slew, 8'h00);
         cyc(10);
         chk("wake", slew, 8'h01);
         rdc("stat_wake", `PVC_OFF_IRQ_STAT, 8'h03);
         wr(`PVC_OFF_IRQ_STAT, 8'h03);
         $display("test stop done");
      end
   endtask
   task v3(input [5:0] b, input e);
      begin
         @(posedge i_ref_clk) b3 <= b;
         cyc(2);
         chk("bit3", {7'h00, v_out[3]}, {7'h00, e});
      end
   endtask
   task t_port_v;
      begin
         @(posedge i_ref_clk) v_ext <= 8'h3C;
         wr(`PVC_OFF_V_DIR, 8'hF0);
         wr(`PVC_OFF_V_DATA, 8'hA5);
         cyc(4);
         rdc("v_read", `PVC_OFF_V_DATA, 8'hAC);
         chk("v_gpio", v_out & 8'hF0, 8'hA0);
         i_motor_en <= 8'hA0;
         i_second_timer_en <= 4'hC;
         i_second_timer_out <= 4'hC;
         cyc(2);
         chk("v_alt", v_out & 8'hF0, 8'h50);
         i_motor_en <= 8'hF0;
         cyc(2);
         chk("v_motor", v_out & 8'hF0, 8'h00);
         v3(6'b111010, 1'b1);
         chk("oe3", {7'h00, v_oe[3]}, 8'h01);
         v3(6'b001110, 1'b1);
         v3(6'b000011, 1'b1);
         v3(6'b101111, 1'b0);
         @(posedge i_ref_clk) i_motor_en <= 8'h08;
         v3(6'b110000, 1'b0);
         $display("test port v done");
      end
   endtask
   task tally_and_finish;
      begin
         $display("checks %0d errors %0d", checks, errors);
         if (errors == 0 && checks > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   initial begin
      #2000000;
      errors = errors + 1;
      tally_and_finish;
   end
   initial begin
      repeat (12) @(posedge i_ref_clk);
      i_reset <= 1'b0;
      cyc(1);
      t_reset;
      t_rsvd;
      t_pull;
      t_slew;
      t_stop;
      t_port_v;
      tally_and_finish;
   end
endmodule
